// ===== design/mux_port_pkg.sv
// shared constants, types and helpers for the multiplexed host port
`default_nettype none
package mux_port_pkg;
	// width of the multiplexed address/data bus
	localparam int BUS_W = 8;
	// level the shared bus floats to when nobody drives it
	localparam logic [7:0] BUS_PULLUP = 8'hFF;
	// bus styles selected by the style input
	localparam logic STYLE_SEPARATE = 1'b0;
	localparam logic STYLE_DATA_STROBE = 1'b1;
	// device register addresses on the shared bus
	localparam logic [7:0] ADDR_PERF_STATUS = 8'h00;
	localparam logic [7:0] ADDR_IRQ_CLEAR_MASK = 8'h01;
	localparam logic [7:0] ADDR_LIVE_STATUS = 8'h02;
	localparam logic [7:0] ADDR_USER_CTRL = 8'h03;
	// reset value of every device register
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// cause bit positions in the performance status register
	localparam int CAUSE_LOS = 0;
	localparam int CAUSE_AIS = 1;
	localparam int CAUSE_NETWORK_LOOPBACK_DETECT = 2;
	localparam int CAUSE_QRSS = 3;
	localparam int CAUSE_DRV_SHORT = 4;
	localparam int CAUSE_DRV_OPEN = 5;
	localparam int CAUSE_ES_OVER = 6;
	localparam int CAUSE_ES_UNDER = 7;
	// idle values of the synchronised pin groups
	localparam logic [11:0] DEV_SYNC_RESET = 12'hBFF;
	localparam logic [8:0] HOST_SYNC_RESET = 9'h1FF;
	// host command port register addresses
	localparam logic [2:0] HADDR_TARGET = 3'h0;
	localparam logic [2:0] HADDR_WDATA = 3'h1;
	localparam logic [2:0] HADDR_CMD = 3'h2;
	localparam logic [2:0] HADDR_STATUS = 3'h3;
	localparam logic [2:0] HADDR_RDATA = 3'h4;
	localparam logic [2:0] HADDR_IRQ_STAT = 3'h5;
	localparam logic [2:0] HADDR_IRQ_MASK = 3'h6;
	// host command and status fields
	localparam int CMD_START_BIT = 0;
	localparam int CMD_READ_BIT = 1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_LINE_BIT = 1;
	localparam int HIRQ_DONE_BIT = 0;
	localparam int HIRQ_DEVINT_BIT = 1;
	// clock cycles in each phase of a host bus cycle
	localparam logic [3:0] PHASE_CYCLES = 4'h8;
	// host bus cycle states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ADDR = 6'h02,
		ST_LATCH = 6'h04,
		ST_STROBE = 6'h08,
		ST_HOLD = 6'h10,
		ST_FINISH = 6'h20
	} host_state_e;
	// true while a read is being asked for, in either bus style
	function automatic logic read_asked(input logic style, input logic strobe_n,
		input logic dir);
		read_asked = (style == STYLE_SEPARATE) ? ~strobe_n : (~strobe_n & dir);
	endfunction : read_asked
	// true while a write is being asked for, in either bus style
	function automatic logic write_asked(input logic style, input logic strobe_n,
		input logic dir);
		write_asked = (style == STYLE_SEPARATE) ? ~dir : (~strobe_n & ~dir);
	endfunction : write_asked
endpackage : mux_port_pkg
`default_nettype wire

// ===== design/mux_port_if.sv
// pin bundle joining the host end and the device end
`default_nettype none
interface mux_port_if;
	import mux_port_pkg::*;
	logic cs_n; // chip select, active low
	logic address_latch_strobe; // high during the address phase; the address stays on the bus after it falls
	logic read_or_data_strobe; // read strobe or data strobe, active low
	logic write_or_dir; // write strobe (low) or direction (high reads)
	logic [BUS_W-1:0] host_bus_out; // host drive value
	logic host_bus_oe; // host drives the shared bus
	logic [BUS_W-1:0] dev_bus_out; // device drive value
	logic dev_bus_oe; // device drives the shared bus
	logic dev_irq_oe; // device pulls the interrupt line low
	logic [BUS_W-1:0] shared_bus; // resolved bus level
	logic irq_line_n; // resolved interrupt line, pulled up
	// resolve the shared bus, pull-up when floating
	assign shared_bus = dev_bus_oe ? dev_bus_out : (host_bus_oe ? host_bus_out : BUS_PULLUP);
	// open-drain interrupt line with external pull-up
	assign irq_line_n = ~dev_irq_oe;
	modport host_end (
		output cs_n, address_latch_strobe, read_or_data_strobe, write_or_dir,
		output host_bus_out, host_bus_oe,
		input shared_bus, irq_line_n
	);
	modport device_end (
		input cs_n, address_latch_strobe, read_or_data_strobe, write_or_dir,
		input shared_bus,
		output dev_bus_out, dev_bus_oe, dev_irq_oe
	);
endinterface : mux_port_if
`default_nettype wire

// ===== design/pin_sync.sv
// two-flop synchroniser for a group of pin inputs
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// pins and their synchronised copy
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta; // first stage, read only by the second
	// two stages; the first is never seen outside
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta <= RESET_VALUE;
			o_sync <= RESET_VALUE;
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end
endmodule : pin_sync
`default_nettype wire

// ===== design/mux_port_device.sv
// device end of the multiplexed host port with interrupt causes
`default_nettype none
// Notes on behaviour
// - separate style: low read strobe reads
// - separate style: low write strobe writes
// - data-strobe style: direction high reads, low writes
// - data strobe low while data on bus
// - write data taken at data strobe rise
// - host holds chip select low whole access
// - device answers only while selected
// - eight lines carry address, then data
// - status bit change pulls interrupt low
// - elastic store over/underflow raises interrupt
// - status register shows interrupt causes
// - clear register one clears, masks; zero enables
// - interrupt is open drain, pulls low only
// - address latch strobe each access
module mux_port_device
	import mux_port_pkg::*;
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// bus style select, steady during operation
	input wire logic i_bus_style,
	// line status levels: los, ais, network_loopback_detect, qrss, drv short, drv open
	input wire logic [5:0] i_line_status,
	// elastic store event pulses
	input wire logic i_es_overflow,
	input wire logic i_es_underflow,
	// user side outputs
	output logic [7:0] o_user_ctrl,
	output logic o_irq,
	// host pins
	mux_port_if.device_end bus
);
	import mux_port_pkg::*;

	logic [11:0] pins_s; // synchronised pins
	logic cs_n_s; // synchronised chip select
	logic ale_s; // synchronised address latch strobe
	logic strobe_n_s; // synchronised read/data strobe
	logic dir_s; // synchronised write strobe or direction
	logic [7:0] bus_s; // synchronised shared bus
	logic ale_q; // address latch strobe one cycle back
	logic wr_q; // write request one cycle back
	logic selected; // chip select asserted
	logic rd_now; // read requested this cycle
	logic wr_now; // write requested this cycle
	logic wr_commit; // end of a write strobe
	logic [7:0] addr; // latched register address
	logic [7:0] wdata; // write data sampled while strobe active
	logic [7:0] cause; // sticky interrupt causes
	logic [7:0] mask; // clear/mask register
	logic [7:0] clr_bits; // causes cleared this cycle
	logic [7:0] set_bits; // causes raised this cycle
	logic [5:0] status_q; // line status one cycle back
	logic primed; // status history valid after reset
	logic pending; // an unmasked cause is pending

	// bring the pins into the clock domain
	pin_sync #(
		.WIDTH(12),
		.RESET_VALUE(DEV_SYNC_RESET)
	) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_async({bus.cs_n, bus.address_latch_strobe, bus.read_or_data_strobe,
			bus.write_or_dir, bus.shared_bus}),
		.o_sync(pins_s)
	);

	// split the synchronised group
	// order matches the concatenation fed to the synchroniser
	assign cs_n_s = pins_s[11];
	assign ale_s = pins_s[10];
	assign strobe_n_s = pins_s[9];
	assign dir_s = pins_s[8];
	assign bus_s = pins_s[7:0];

	// access decode, gated by chip select
	// both styles decode from the same two pins; the style input picks the meaning
	// the select gate keeps traffic for other devices on a shared bus away
	assign selected = ~cs_n_s;
	assign rd_now = selected & read_asked(i_bus_style, strobe_n_s, dir_s);
	assign wr_now = selected & write_asked(i_bus_style, strobe_n_s, dir_s);
	// a write lands when its strobe rises
	assign wr_commit = wr_q & ~wr_now;

	// edge history for the strobes
	// reset levels match the idle pins, so no false edge follows reset
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ale_q <= 1'b0;
			wr_q <= 1'b0;
		end else begin
			ale_q <= ale_s;
			wr_q <= wr_now;
		end
	end

	// latch the address phase when the latch strobe falls
	// the address stays on the bus after the strobe falls, so the
	// two-flop lag cannot miss it
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			addr <= RESET_BYTE;
		end else if (selected && ale_q && !ale_s) begin
			addr <= bus_s;
		end
	end

	// keep the last data seen while the write strobe is active
	// the final sample before the strobe rises is the one that commits
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wdata <= RESET_BYTE;
		end else if (wr_now) begin
			wdata <= bus_s;
		end
	end

	// user control register
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_user_ctrl <= RESET_BYTE;
		end else if (wr_commit && addr == ADDR_USER_CTRL) begin
			o_user_ctrl <= wdata;
		end
	end

	// clear/mask register: a one masks, a zero enables again
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mask <= RESET_BYTE;
		end else if (wr_commit && addr == ADDR_IRQ_CLEAR_MASK) begin
			mask <= wdata;
		end
	end

	// status history, primed one cycle after reset
	// without priming, the first cycle would compare against the reset
	// value and could raise a false change
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			status_q <= 6'h00;
			primed <= 1'b0;
		end else begin
			status_q <= i_line_status;
			primed <= 1'b1;
		end
	end

	// events: any status change and elastic store slips
	// elastic store pulses set their bit for every cycle they are high
	always_comb begin
		set_bits = 8'h00;
		set_bits[CAUSE_DRV_OPEN:CAUSE_LOS] = primed ? (i_line_status ^ status_q) : 6'h00;
		set_bits[CAUSE_ES_OVER] = i_es_overflow;
		set_bits[CAUSE_ES_UNDER] = i_es_underflow;
	end

	// writing ones to the clear register clears those causes
	// a zero clears nothing; it only re-enables through the mask
	assign clr_bits = (wr_commit && addr == ADDR_IRQ_CLEAR_MASK) ? wdata : 8'h00;

	// sticky causes; a new event wins over a clear in the same cycle
	// a masked cause still records events, so software can poll it
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cause <= RESET_BYTE;
		end else begin
			cause <= (cause & ~clr_bits) | set_bits;
		end
	end

	// unmasked causes drive the interrupt
	assign pending = |(cause & ~mask);

	// open-drain interrupt: only ever pulls low
	// the pin is released, never driven high; the pull-up gives the level
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bus.dev_irq_oe <= 1'b0;
			o_irq <= 1'b0;
		end else begin
			bus.dev_irq_oe <= pending;
			o_irq <= pending;
		end
	end

	// read mux and bus drive, only during a selected read
	// read data follow the latched address; the bus is driven only while
	// the selected read is held, so the host never meets a clash
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bus.dev_bus_out <= RESET_BYTE;
			bus.dev_bus_oe <= 1'b0;
		end else begin
			bus.dev_bus_oe <= rd_now;
			case (addr)
				ADDR_PERF_STATUS: bus.dev_bus_out <= cause;
				ADDR_IRQ_CLEAR_MASK: bus.dev_bus_out <= mask;
				ADDR_LIVE_STATUS: bus.dev_bus_out <= {2'b00, i_line_status};
				ADDR_USER_CTRL: bus.dev_bus_out <= o_user_ctrl;
				default: bus.dev_bus_out <= RESET_BYTE;
			endcase
		end
	end
endmodule : mux_port_device
`default_nettype wire

// ===== design/mux_port_host.sv
// host end: runs multiplexed bus cycles on command from software
`default_nettype none
module mux_port_host
	import mux_port_pkg::*;
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// bus style select, steady during operation
	input wire logic i_bus_style,
	// software command port
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// interrupt to software
	output logic o_irq,
	// device pins
	mux_port_if.host_end bus
);
	import mux_port_pkg::*;

	host_state_e state; // bus cycle state
	host_state_e next_state; // state after this cycle
	logic [8:0] pins_s; // synchronised bus and interrupt line
	logic [3:0] phase_cnt; // cycles left in this phase
	logic phase_end; // last cycle of a phase
	logic [7:0] target; // device register address
	logic [7:0] wbyte; // byte to write
	logic is_read; // current access reads
	logic [7:0] result; // byte read back
	logic start; // software starts an access
	logic [1:0] irq_stat; // sticky done / device interrupt
	logic [1:0] irq_mask; // interrupt enables
	logic [1:0] irq_set; // events this cycle
	logic [1:0] irq_clr; // write-one clears this cycle
	logic line_q; // interrupt line one cycle back

	// bring the bus and interrupt line into the clock domain
	pin_sync #(
		.WIDTH(9),
		.RESET_VALUE(HOST_SYNC_RESET)
	) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_async({bus.irq_line_n, bus.shared_bus}),
		.o_sync(pins_s)
	);

	// start only from idle; a start while busy is dropped
	assign start = i_wr && i_addr == HADDR_CMD && i_wdata[CMD_START_BIT] && state == ST_IDLE;
	assign phase_end = (phase_cnt == 4'h0);

	// next state: each phase lasts a fixed number of cycles
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: if (start) next_state = ST_ADDR;
			ST_ADDR: if (phase_end) next_state = ST_LATCH;
			ST_LATCH: if (phase_end) next_state = ST_STROBE;
			ST_STROBE: if (phase_end) next_state = ST_HOLD;
			ST_HOLD: if (phase_end) next_state = ST_FINISH;
			ST_FINISH: if (phase_end) next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	// state and phase counter
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= ST_IDLE;
			phase_cnt <= 4'h0;
		end else begin
			state <= next_state;
			phase_cnt <= (next_state != state) ? PHASE_CYCLES - 4'h1 : phase_cnt - 4'h1;
		end
	end

	// pin levels for the coming state
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bus.cs_n <= 1'b1;
			bus.address_latch_strobe <= 1'b0;
			bus.read_or_data_strobe <= 1'b1;
			bus.write_or_dir <= 1'b1;
			bus.host_bus_out <= BUS_PULLUP;
			bus.host_bus_oe <= 1'b0;
		end else begin
			// select held from address phase through hold phase
			bus.cs_n <= (next_state == ST_IDLE) || (next_state == ST_FINISH);
			bus.address_latch_strobe <= (next_state == ST_ADDR);
			// strobe low only in the strobe phase
			bus.read_or_data_strobe <= ~((next_state == ST_STROBE) &&
				(is_read || i_bus_style == STYLE_DATA_STROBE));
			// write strobe low, or direction level, as the style asks
			if (i_bus_style == STYLE_SEPARATE) begin
				bus.write_or_dir <= ~((next_state == ST_STROBE) && !is_read);
			end else begin
				bus.write_or_dir <= (next_state == ST_IDLE) || is_read;
			end
			// address first, then write data through the hold phase
			bus.host_bus_out <= (next_state == ST_ADDR || next_state == ST_LATCH) ? target : wbyte;
			bus.host_bus_oe <= (next_state == ST_ADDR) || (next_state == ST_LATCH) ||
				(!is_read && (next_state == ST_STROBE || next_state == ST_HOLD));
		end
	end

	// command registers from software
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			target <= 8'h00;
			wbyte <= 8'h00;
			is_read <= 1'b0;
		end else begin
			if (i_wr && i_addr == HADDR_TARGET && state == ST_IDLE) target <= i_wdata;
			if (i_wr && i_addr == HADDR_WDATA && state == ST_IDLE) wbyte <= i_wdata;
			if (start) is_read <= i_wdata[CMD_READ_BIT];
		end
	end

	// capture read data at the end of the strobe phase
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			result <= 8'h00;
		end else if (state == ST_STROBE && phase_end && is_read) begin
			result <= pins_s[7:0];
		end
	end

	// events: access done, device interrupt line falls
	assign irq_set[HIRQ_DONE_BIT] = (state == ST_FINISH) && phase_end;
	assign irq_set[HIRQ_DEVINT_BIT] = line_q & ~pins_s[8];
	assign irq_clr = (i_wr && i_addr == HADDR_IRQ_STAT) ? i_wdata[1:0] : 2'b00;

	// sticky status, set wins over clear; mask; line history
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_stat <= 2'b00;
			irq_mask <= 2'b00;
			line_q <= 1'b1;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
			if (i_wr && i_addr == HADDR_IRQ_MASK) irq_mask <= i_wdata[1:0];
			line_q <= pins_s[8];
		end
	end

	// interrupt output and read port
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_irq <= 1'b0;
			o_rdata <= 8'h00;
		end else begin
			o_irq <= |((irq_stat & ~irq_clr | irq_set) & irq_mask);
			o_rdata <= 8'h00;
			if (i_rd) begin
				case (i_addr)
					HADDR_TARGET: o_rdata <= target;
					HADDR_WDATA: o_rdata <= wbyte;
					HADDR_STATUS: o_rdata <= {6'h00, ~pins_s[8], state != ST_IDLE};
					HADDR_RDATA: o_rdata <= result;
					HADDR_IRQ_STAT: o_rdata <= {6'h00, irq_stat};
					HADDR_IRQ_MASK: o_rdata <= {6'h00, irq_mask};
					default: o_rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule : mux_port_host
`default_nettype wire

// ===== testbench/mux_port_asserts.sv
// concurrent checks on the pins joining the host end and the device end
`default_nettype none
module mux_port_asserts (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// bus style select, as given to both ends
	input wire logic i_bus_style,
	// pins of the joining interface
	input wire logic cs_n,
	input wire logic address_latch_strobe,
	input wire logic read_or_data_strobe,
	input wire logic write_or_dir,
	input wire logic [mux_port_pkg::BUS_W-1:0] host_bus_out,
	input wire logic host_bus_oe,
	input wire logic [mux_port_pkg::BUS_W-1:0] dev_bus_out,
	input wire logic dev_bus_oe,
	input wire logic dev_irq_oe,
	input wire logic [mux_port_pkg::BUS_W-1:0] shared_bus,
	input wire logic irq_line_n
);
	timeunit 1ns;
	timeprecision 1ps;
	import mux_port_pkg::*;
	// high while a read or write strobe is active; in data-strobe style the
	// direction line is a level held for the whole access, not a strobe
	logic strb_act;
	// high while a write is being strobed, in either bus style
	logic wr_act;
	assign strb_act = !read_or_data_strobe ||
		(i_bus_style == STYLE_SEPARATE && !write_or_dir);
	assign wr_act = (i_bus_style == STYLE_SEPARATE) ? !write_or_dir :
		(!read_or_data_strobe && !write_or_dir);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);
	// address held on the bus, selected, no strobe yet
	sequence seq_latch;
		(!cs_n && !strb_act && host_bus_oe)[*8];
	endsequence
	// strobe phase of fixed length, then released
	sequence seq_strobe;
		strb_act[*8] ##1 !strb_act;
	endsequence
	addr_drive_a: assert property (address_latch_strobe |-> !cs_n && host_bus_oe && !dev_bus_oe)
		else $error("address phase not driven by host alone");
	latch_order_a: assert property ($fell(address_latch_strobe) |-> seq_latch ##1 strb_act)
		else $error("strobe did not follow the address latch");
	strobe_len_a: assert property ($rose(strb_act) |-> seq_strobe)
		else $error("strobe phase length wrong");
	cs_hold_a: assert property (strb_act |-> !cs_n)
		else $error("strobe active without chip select");
	read_drive_a: assert property ((!cs_n && !read_or_data_strobe && write_or_dir)[*4] |-> dev_bus_oe)
		else $error("device not answering a held read");
	write_quiet_a: assert property (wr_act |-> host_bus_oe && !dev_bus_oe)
		else $error("device drives the bus during a write");
	select_only_a: assert property (cs_n[*4] |-> !dev_bus_oe)
		else $error("device drives the bus while deselected");
	idle_release_a: assert property (cs_n |-> !host_bus_oe)
		else $error("host drives the bus while deselected");
endmodule : mux_port_asserts
`default_nettype wire

// ===== testbench/mux_bus_host_port_irq_bench.sv
// self-checking bench: host end and device end joined over the pin bundle
`default_nettype none
module mux_bus_host_port_irq_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import mux_port_pkg::*;
	logic i_clk_sys, i_rst_n, i_bus_style, i_es_overflow, i_es_underflow, i_wr, i_rd;
	logic [5:0] i_line_status; // line status levels into the device
	logic [2:0] i_addr; // software command port address
	logic [7:0] i_wdata, h_rdata, user_ctrl, q, d;
	logic h_irq, d_irq; // host and device interrupt outputs
	int err_count, samples_checked;
	mux_port_if u_mux_port_if ();
	mux_port_host u_mux_port_host (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
		.i_bus_style(i_bus_style), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(h_rdata), .o_irq(h_irq), .bus(u_mux_port_if));
	mux_port_device u_mux_port_device (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
		.i_bus_style(i_bus_style), .i_line_status(i_line_status),
		.i_es_overflow(i_es_overflow), .i_es_underflow(i_es_underflow),
		.o_user_ctrl(user_ctrl), .o_irq(d_irq), .bus(u_mux_port_if));
	mux_port_asserts u_mux_port_asserts (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
		.i_bus_style(i_bus_style),
		.cs_n(u_mux_port_if.cs_n), .address_latch_strobe(u_mux_port_if.address_latch_strobe),
		.read_or_data_strobe(u_mux_port_if.read_or_data_strobe),
		.write_or_dir(u_mux_port_if.write_or_dir), .host_bus_out(u_mux_port_if.host_bus_out),
		.host_bus_oe(u_mux_port_if.host_bus_oe), .dev_bus_out(u_mux_port_if.dev_bus_out),
		.dev_bus_oe(u_mux_port_if.dev_bus_oe), .dev_irq_oe(u_mux_port_if.dev_irq_oe),
		.shared_bus(u_mux_port_if.shared_bus), .irq_line_n(u_mux_port_if.irq_line_n));
	// 125 MHz system clock
	initial begin
		i_clk_sys = 1'b0;
		forever #4 i_clk_sys = ~i_clk_sys;
	end
	// compare one value and count it
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: %s saw %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	// print the counts and the verdict, then stop
	task automatic wrap_up();
		$display("counts: %0d compared, %0d mismatched", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up
	// one-cycle software write
	task automatic hwr(input logic [2:0] a, input logic [7:0] v);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask : hwr
	// one-cycle software read, data taken in the following cycle
	task automatic hrd(input logic [2:0] a, output logic [7:0] v);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1 v = h_rdata;
	endtask : hrd
	// full device access through the host: target, data, start, poll busy
	task automatic dev_acc(input logic [7:0] a, input logic [7:0] v, input logic rd,
		output logic [7:0] r);
		int n;
		n = 0;
		hwr(HADDR_TARGET, a);
		hwr(HADDR_WDATA, v);
		hwr(HADDR_CMD, {6'h00, rd, 1'b1});
		do begin
			hrd(HADDR_STATUS, r);
			n++;
		end while (r[STAT_BUSY_BIT] !== 1'b0 && n < 100);
		// a bus cycle that never ends stops the run
		if (r[STAT_BUSY_BIT] !== 1'b0) begin
			err_count++;
			$display("mismatch at %0t: access never finished", $time);
			wrap_up();
		end
		if (rd) begin
			hrd(HADDR_RDATA, r);
		end
	endtask : dev_acc
	// raise one interrupt cause: line level toggle or elastic store pulse
	task automatic kick(input int k);
		@(posedge i_clk_sys);
		if (k < 6) begin
			i_line_status[k] <= ~i_line_status[k];
		end else if (k == 6) begin
			i_es_overflow <= 1'b1;
		end else begin
			i_es_underflow <= 1'b1;
		end
		@(posedge i_clk_sys);
		i_es_overflow <= 1'b0;
		i_es_underflow <= 1'b0;
		repeat (6) @(posedge i_clk_sys);
		#1;
	endtask : kick
	// cut a hung run short
	initial begin
		repeat (100000) @(posedge i_clk_sys);
		err_count++;
		$display("mismatch at %0t: run too long", $time);
		wrap_up();
	end
	// main sequence, once per bus style
	initial begin
		{i_rst_n, i_bus_style, i_es_overflow, i_es_underflow, i_wr, i_rd} = 6'h00;
		i_line_status = 6'h00;
		i_addr = 3'h0;
		i_wdata = 8'h00;
		err_count = 0;
		samples_checked = 0;
		for (int s = 0; s < 2; s++) begin
			// reset held 8 cycles, style chosen while in reset
			@(posedge i_clk_sys);
			i_rst_n <= 1'b0;
			i_bus_style <= s[0];
			repeat (8) @(posedge i_clk_sys);
			i_rst_n <= 1'b1;
			#1;
			check(h_rdata, 8'h00, "host read data at reset");
			check(user_ctrl, RESET_BYTE, "user reg at reset");
			d = s[0] ? 8'hC3 : 8'h5A;
			hwr(HADDR_IRQ_MASK, 8'h03);
			dev_acc(ADDR_USER_CTRL, d, 1'b0, q);
			check(user_ctrl, d, "user reg after write");
			check({7'h00, h_irq}, 8'h01, "host done irq");
			hrd(HADDR_IRQ_STAT, q);
			check(q, 8'h01, "host irq status");
			hwr(HADDR_IRQ_STAT, 8'h01);
			repeat (2) @(posedge i_clk_sys);
			#1 check({7'h00, h_irq}, 8'h00, "host irq after clear");
			dev_acc(ADDR_USER_CTRL, 8'h00, 1'b1, q);
			check(q, d, "user reg read back");
			dev_acc(ADDR_PERF_STATUS, 8'hFF, 1'b0, q);
			dev_acc(ADDR_PERF_STATUS, 8'h00, 1'b1, q);
			check(q, 8'h00, "status reg not writable");
			dev_acc(8'h3C, 8'h00, 1'b1, q);
			check(q, 8'h00, "unmapped device read");
			hrd(3'h7, q);
			check(q, 8'h00, "unmapped host read");
			// every cause: raise, read, clear and mask, masked event, re-enable
			for (int k = 0; k < 8; k++) begin
				kick(k);
				check({7'h00, d_irq}, 8'h01, "irq on cause");
				check({7'h00, u_mux_port_if.irq_line_n}, 8'h00, "irq line low");
				hrd(HADDR_IRQ_STAT, q);
				check({7'h00, q[HIRQ_DEVINT_BIT]}, 8'h01, "host saw device irq");
				hrd(HADDR_STATUS, q);
				check({7'h00, q[STAT_LINE_BIT]}, 8'h01, "host sees line low");
				hwr(HADDR_IRQ_STAT, 8'h03);
				dev_acc(ADDR_PERF_STATUS, 8'h00, 1'b1, q);
				check(q, 8'h01 << k, "cause register");
				dev_acc(ADDR_LIVE_STATUS, 8'h00, 1'b1, q);
				check(q, {2'b00, i_line_status}, "live status");
				dev_acc(ADDR_IRQ_CLEAR_MASK, 8'h01 << k, 1'b0, q);
				check({7'h00, d_irq}, 8'h00, "irq after clear");
				check({7'h00, u_mux_port_if.irq_line_n}, 8'h01, "irq line released");
				dev_acc(ADDR_IRQ_CLEAR_MASK, 8'h00, 1'b1, q);
				check(q, 8'h01 << k, "mask readback");
				kick(k);
				check({7'h00, d_irq}, 8'h00, "masked cause quiet");
				dev_acc(ADDR_IRQ_CLEAR_MASK, 8'h00, 1'b0, q);
				check({7'h00, d_irq}, 8'h01, "pending cause after enable");
				dev_acc(ADDR_IRQ_CLEAR_MASK, 8'h01 << k, 1'b0, q);
				dev_acc(ADDR_IRQ_CLEAR_MASK, 8'h00, 1'b0, q);
				check({7'h00, d_irq}, 8'h00, "irq gone when cleared");
			end
			$display("test for bus style %0d done", s);
		end
		wrap_up();
	end
endmodule : mux_bus_host_port_irq_bench
`default_nettype wire
